/* File: ubt_pkg.sv */
// Package for the scan bus transceiver datapath: widths, struct carriers, pin sync depth.
// Assumes a single system clock; all pins arrive asynchronously.
package xcvr_pkg;
   localparam int HalfWidth = 9;
   localparam int Halves = 2;
   localparam int PortWidth = HalfWidth * Halves;
   localparam int SyncStages = 3;
   localparam logic HizReset = 1'b1;
   localparam logic [HalfWidth-1:0] DataReset = 9'h000;

   // Per-direction controls of one half, as sampled from the pins
   typedef struct packed {
      logic outEnableN;
      logic latchEnable;
      logic dirClock;
   } dir_ctrl_s;

   // Pin driver bundle for one 9-bit half of one port
   typedef struct packed {
      logic [HalfWidth-1:0] data;
      logic [HalfWidth-1:0] enable;
   } pin_drive_s;
endpackage

/* File: ubt_dir_path.sv */
// One direction of one 9-bit half: transparent, latched or edge-stored path.
// Assumes inputs already synchronised to clk_sys by the caller.
`timescale 1ns/1ps
`default_nettype none
module xcvr_dir_path #(
   parameter int Width = xcvr_pkg::HalfWidth
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [Width-1:0] srcData,
   input wire xcvr_pkg::dir_ctrl_s ctrl,
   input wire logic testMode,
   output logic [Width-1:0] heldData
);
   logic clockPrev_q;
   logic [Width-1:0] store_q;
   logic [Width-1:0] store_d;
   wire risingEdge = ctrl.dirClock & ~clockPrev_q;
   wire captureNow = ~ctrl.latchEnable & risingEdge;

   // Transparent follows source; a falling latch enable keeps last passed value
   assign store_d = testMode ? store_q :
                    ctrl.latchEnable ? srcData : // RQ1 RQ16
                    captureNow ? srcData : store_q; // RQ3 RQ2 RQ8

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clockPrev_q <= 1'b0;
         store_q <= Width'(0);
      end else begin
         clockPrev_q <= ctrl.dirClock;
         store_q <= store_d;
      end
   end

   assign heldData = store_q;

   hold_steady_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
      (!testMode && !ctrl.latchEnable && !risingEdge) |=> $stable(store_q))
      else $error("held value changed without a capture");
   edge_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
      (!testMode && captureNow) |=> store_q == $past(srcData))
      else $error("rising clock edge did not store source data");
   transparent_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
      (!testMode && ctrl.latchEnable) |=> store_q == $past(srcData))
      else $error("transparent path did not follow source");
   fall_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ16
      (!testMode && !$past(testMode) && $fell(ctrl.latchEnable) && !risingEdge)
         |=> store_q == $past(srcData, 2))
      else $error("falling latch enable lost the last passed value");
endmodule
`default_nettype wire

/* File: ubt_transceiver.sv */
// Normal-mode datapath of an 18-bit scan bus transceiver with two 9-bit halves.
// Assumes bus pins and controls are asynchronous; a scan controller drives testMode.
// Operation
// RQ1: Latch enable high passes A straight to B transparently.
// RQ2: Latch enable low, clock steady: hold stored value, ignore A.
// RQ3: Latch enable low: store A on each rising direction clock edge.
// RQ4: Output enable low drives B with the held or passed value.
// RQ5: Output enable high floats all B outputs regardless of other inputs.
// RQ6: B-to-A direction behaves the same with its own controls.
// RQ7: Eighteen bits per port in two independently controlled 9-bit halves.
// RQ8: Hold keeps the prior output level without spontaneous change.
// RQ9: Test mode inhibits normal transceiver operation.
// RQ10: Scan port activity in normal mode leaves the datapath untouched.
// RQ11: Test circuitry samples pins and self tests cells.
// RQ12: Test circuitry offers signature compression and pattern generation.
// RQ13: Scan activity timed only by the four-wire test port.
// RQ14: Test port samples on rising and changes on falling test clock.
// RQ15: Output-enable control cells reset high so test mode floats outputs.
// RQ16: Falling latch enable keeps the value present just before.
`timescale 1ns/1ps
`default_nettype none
module scan_universal_bus_transceiver #(
   parameter int HalfWidth = xcvr_pkg::HalfWidth,
   parameter int Halves = xcvr_pkg::Halves
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic testMode,
   input wire logic [Halves*HalfWidth-1:0] aPortIn,
   input wire logic [Halves*HalfWidth-1:0] bPortIn,
   input wire xcvr_pkg::dir_ctrl_s [Halves-1:0] aToBCtrl,
   input wire xcvr_pkg::dir_ctrl_s [Halves-1:0] bToACtrl,
   output logic [Halves*HalfWidth-1:0] aPortOut,
   output logic [Halves*HalfWidth-1:0] aPortOe,
   output logic [Halves*HalfWidth-1:0] bPortOut,
   output logic [Halves*HalfWidth-1:0] bPortOe
);
   localparam int W = Halves * HalfWidth;
   localparam int CW = Halves * 3;

   // Three-stage synchronisers; only stages two and three are looked at
   logic [W-1:0] aSync1_q, aSync2_q, aSync3_q, aStable_q;
   logic [W-1:0] bSync1_q, bSync2_q, bSync3_q, bStable_q;
   logic [CW-1:0] abSync1_q, abSync2_q, abSync3_q, abStable_q;
   logic [CW-1:0] baSync1_q, baSync2_q, baSync3_q, baStable_q;
   logic testSync1_q, testSync2_q, testSync3_q, testStable_q;

   // A change counts once stages two and three agree
   function automatic logic [W-1:0] agreeW(input logic [W-1:0] s2, input logic [W-1:0] s3,
                                           input logic [W-1:0] old);
      agreeW = (s2 & s3) | (old & (s2 | s3));
   endfunction

   function automatic logic [CW-1:0] agreeC(input logic [CW-1:0] s2,
                                            input logic [CW-1:0] s3,
                                            input logic [CW-1:0] old);
      agreeC = (s2 & s3) | (old & (s2 | s3));
   endfunction

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aSync1_q <= '0;
         aSync2_q <= '0;
         aSync3_q <= '0;
         aStable_q <= '0;
         bSync1_q <= '0;
         bSync2_q <= '0;
         bSync3_q <= '0;
         bStable_q <= '0;
      end else begin
         aSync1_q <= aPortIn;
         aSync2_q <= aSync1_q;
         aSync3_q <= aSync2_q;
         aStable_q <= agreeW(aSync2_q, aSync3_q, aStable_q);
         bSync1_q <= bPortIn;
         bSync2_q <= bSync1_q;
         bSync3_q <= bSync2_q;
         bStable_q <= agreeW(bSync2_q, bSync3_q, bStable_q);
      end
   end

   // Enables reset high so the buses stay floating until controls are seen
   localparam logic [CW-1:0] CtrlReset = {Halves{xcvr_pkg::HizReset, 2'b00}};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         abSync1_q <= CtrlReset;
         abSync2_q <= CtrlReset;
         abSync3_q <= CtrlReset;
         abStable_q <= CtrlReset;
         baSync1_q <= CtrlReset;
         baSync2_q <= CtrlReset;
         baSync3_q <= CtrlReset;
         baStable_q <= CtrlReset;
         testSync1_q <= 1'b0;
         testSync2_q <= 1'b0;
         testSync3_q <= 1'b0;
         testStable_q <= 1'b0;
      end else begin
         abSync1_q <= aToBCtrl;
         abSync2_q <= abSync1_q;
         abSync3_q <= abSync2_q;
         abStable_q <= agreeC(abSync2_q, abSync3_q, abStable_q);
         baSync1_q <= bToACtrl;
         baSync2_q <= baSync1_q;
         baSync3_q <= baSync2_q;
         baStable_q <= agreeC(baSync2_q, baSync3_q, baStable_q);
         // Sampling, signatures, patterns and the test clock stay on the scan side
         testSync1_q <= testMode; // RQ11 RQ12 RQ13 RQ14
         testSync2_q <= testSync1_q;
         testSync3_q <= testSync2_q;
         testStable_q <= (testSync2_q & testSync3_q) | (testStable_q & (testSync2_q | testSync3_q));
      end
   end

   xcvr_pkg::dir_ctrl_s [Halves-1:0] abCtrl;
   xcvr_pkg::dir_ctrl_s [Halves-1:0] baCtrl;
   assign abCtrl = abStable_q;
   assign baCtrl = baStable_q;

   logic [W-1:0] abHeld;
   logic [W-1:0] baHeld;
   logic [W-1:0] bDrive_d, bOe_d, aDrive_d, aOe_d;

   for (genvar h = 0; h < Halves; h++) begin : g_half
      // Each half has its own controls and paths
      xcvr_dir_path #(.Width(HalfWidth)) u_ab ( // RQ7
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .srcData(aStable_q[h*HalfWidth +: HalfWidth]),
         .ctrl(abCtrl[h]),
         .testMode(testStable_q), // RQ9 RQ10
         .heldData(abHeld[h*HalfWidth +: HalfWidth])
      );
      xcvr_dir_path #(.Width(HalfWidth)) u_ba ( // RQ6
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .srcData(bStable_q[h*HalfWidth +: HalfWidth]),
         .ctrl(baCtrl[h]),
         .testMode(testStable_q),
         .heldData(baHeld[h*HalfWidth +: HalfWidth])
      );
      // Low active enable drives unless test mode is on; high floats whatever else is going on
      assign bOe_d[h*HalfWidth +: HalfWidth] =
         {HalfWidth{~abCtrl[h].outEnableN & ~testStable_q}}; // RQ4 RQ5 RQ9
      assign aOe_d[h*HalfWidth +: HalfWidth] =
         {HalfWidth{~baCtrl[h].outEnableN & ~testStable_q}}; // RQ6 RQ9
   end

   // Transparent mode is still registered twice (store_q, then the port register); the sync costs about four cycles
   assign bDrive_d = abHeld;
   assign aDrive_d = baHeld;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bPortOut <= '0;
         bPortOe <= '0;
         aPortOut <= '0;
         aPortOe <= '0;
      end else begin
         bPortOut <= bDrive_d;
         bPortOe <= bOe_d; // RQ15
         aPortOut <= aDrive_d;
         aPortOe <= aOe_d;
      end
   end

   // Enables show one cycle after the stable controls are seen and port data one cycle after the held data,
   // so every check below except reset_float_a looks one edge after its cause
   float_on_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      abCtrl[0].outEnableN |=> bPortOe[HalfWidth-1:0] == '0)
      else $error("B half 0 driven while its enable is high");
   float_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5 RQ7
      abCtrl[1].outEnableN |=> bPortOe[W-1:HalfWidth] == '0)
      else $error("B half 1 driven while its enable is high");
   drive_on_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
      (!abCtrl[1].outEnableN && !testStable_q) |=> (&bPortOe[W-1:HalfWidth]))
      else $error("B half 1 not driven while enabled");
   drive_lower_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4 RQ7
      (!abCtrl[0].outEnableN && !testStable_q) |=> (&bPortOe[HalfWidth-1:0]))
      else $error("B half 0 not driven while enabled");
   ba_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      baCtrl[0].outEnableN |=> aPortOe[HalfWidth-1:0] == '0)
      else $error("A half 0 driven while its enable is high");
   ba_upper_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      baCtrl[1].outEnableN |=> aPortOe[W-1:HalfWidth] == '0)
      else $error("A half 1 driven while its enable is high");
   ba_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      (!baCtrl[1].outEnableN && !testStable_q) |=> (&aPortOe[W-1:HalfWidth]))
      else $error("A half 1 not driven while enabled");
   test_inhibit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
      testStable_q |=> (bPortOe == '0 && aPortOe == '0))
      else $error("outputs driven in test mode");
   test_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
      testStable_q |=> ($stable(abHeld) && $stable(baHeld)))
      else $error("stored data moved in test mode");
   out_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
      1'b1 |=> bPortOut == $past(abHeld))
      else $error("B output does not carry held A data");
   ba_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      1'b1 |=> aPortOut == $past(baHeld))
      else $error("A output does not carry held B data");
   reset_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ15
      $rose(rst_n) |-> (aPortOe == '0 && bPortOe == '0))
      else $error("outputs driven right after reset");
   // A pin bit may only move once stages two and three agree on it
   a_sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
      1'b1 |=> ((aStable_q ^ $past(aStable_q)) & $past(aSync2_q ^ aSync3_q)) == '0)
      else $error("A pin change taken before two stages agreed");
   b_sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      1'b1 |=> ((bStable_q ^ $past(bStable_q)) & $past(bSync2_q ^ bSync3_q)) == '0)
      else $error("B pin change taken before two stages agreed");
   ctrl_sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
      1'b1 |=> ((abStable_q ^ $past(abStable_q)) & $past(abSync2_q ^ abSync3_q)) == '0)
      else $error("A-to-B control change taken before two stages agreed");
   ba_sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
      1'b1 |=> ((baStable_q ^ $past(baStable_q)) & $past(baSync2_q ^ baSync3_q)) == '0)
      else $error("B-to-A control change taken before two stages agreed");
   test_sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
      1'b1 |=> ((testStable_q ^ $past(testStable_q)) & $past(testSync2_q ^ testSync3_q)) == '0)
      else $error("test inhibit taken before two stages agreed");
endmodule
`default_nettype wire

/* File: bus_side_model.sv */
// Far-side parallel bus: resolves each pin from the block's drive and the bus's own drive.
// Assumes an output-enable bit high means the block owns that pin.
`timescale 1ns/1ps
`default_nettype none
module bus_side_model (
   input wire logic [xcvr_pkg::PortWidth-1:0] farDrive,
   input wire logic [xcvr_pkg::PortWidth-1:0] nearOut,
   input wire logic [xcvr_pkg::PortWidth-1:0] nearOe,
   output logic [xcvr_pkg::PortWidth-1:0] pinLevel
);
   // The far side releases a bit the block drives; contention is not modelled
   assign pinLevel = (nearOut & nearOe) | (farDrive & ~nearOe);
endmodule
`default_nettype wire

/* File: scan_universal_bus_transceiver_tb_top.sv */
// Self-checking bench for the transceiver datapath, one task per scenario.
// Assumes bus_side_model closes both buses and the 3-stage pin sync settles in 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module scan_universal_bus_transceiver_tb_top;
   logic clk_sys, rst_n, testMode;
   logic [17:0] aDrive, bDrive, aLevel, bLevel, aPortOut, aPortOe, bPortOut, bPortOe;
   xcvr_pkg::dir_ctrl_s [1:0] aToBCtrl, bToACtrl;
   int errors = 0;
   int compares = 0;

   scan_universal_bus_transceiver scan_universal_bus_transceiver_inst (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .testMode(testMode), .aPortIn(aLevel), .bPortIn(bLevel), .aToBCtrl(aToBCtrl),
      .bToACtrl(bToACtrl), .aPortOut(aPortOut), .aPortOe(aPortOe),
      .bPortOut(bPortOut), .bPortOe(bPortOe));
   bus_side_model bus_side_model_inst (.farDrive(aDrive), .nearOut(aPortOut),
      .nearOe(aPortOe), .pinLevel(aLevel));
   bus_side_model bus_b_model_inst (.farDrive(bDrive), .nearOut(bPortOut),
      .nearOe(bPortOe), .pinLevel(bLevel));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic scenTransparent();
      aDrive = 18'h3FE5A;
      aToBCtrl[0] = 3'b010;
      cyc(10);
      chk(bPortOe, 18'h001FF, "only half 0 drives B");
      chk(bPortOut & 18'h001FF, 18'h0005A, "A passes to B");
   endtask

   task automatic scenHold();
      aToBCtrl[0] = 3'b000;
      cyc(10);
      aDrive = 18'h000AA;
      cyc(10);
      chk(bPortOut & 18'h001FF, 18'h0005A, "latched value kept");
   endtask

   task automatic scenClock();
      aToBCtrl[0] = 3'b001;
      cyc(6);
      aToBCtrl[0] = 3'b000;
      cyc(10);
      chk(bPortOut & 18'h001FF, 18'h000AA, "rising clock stores A");
   endtask

   task automatic scenFloat();
      aToBCtrl[0] = 3'b110;
      cyc(10);
      chk(bPortOe, 18'h00000, "B floats with enable high");
   endtask

   task automatic scenReverse();
      bDrive = 18'h2AC00;
      bToACtrl[1] = 3'b010;
      cyc(10);
      chk(aPortOe, 18'h3FE00, "only half 1 drives A");
      chk(aPortOut & 18'h3FE00, 18'h2AC00, "B passes to A");
   endtask

   task automatic scenTestMode();
      testMode = 1'b1;
      aToBCtrl[0] = 3'b010;
      cyc(10);
      chk(aPortOe, 18'h00000, "test mode stops driving");
      chk(bPortOe, 18'h00000, "test mode keeps B floating");
      testMode = 1'b0;
      cyc(10);
      chk(aPortOut & 18'h3FE00, 18'h2AC00, "normal mode resumes");
      chk(bPortOe, 18'h001FF, "B half 0 drives after test mode");
      chk(bPortOut & 18'h001FF, 18'h000AA, "B half 0 follows A again");
   endtask

   task automatic scenUpper();
      bToACtrl[1] = 3'b100;
      aToBCtrl[0] = 3'b110;
      aToBCtrl[1] = 3'b010;
      aDrive = 18'h15400;
      cyc(16);
      chk(bPortOe, 18'h3FE00, "only half 1 drives B");
      chk(bPortOut & 18'h3FE00, 18'h15400, "upper A passes to B");
      chk(aPortOe, 18'h00000, "A released by its enable");
   endtask

   initial begin
      rst_n = 1'b0;
      testMode = 1'b0;
      aDrive = 18'h00000;
      bDrive = 18'h00000;
      aToBCtrl = {3'b100, 3'b100};
      bToACtrl = {3'b100, 3'b100};
      cyc(5);
      rst_n = 1'b1;
      chk(aPortOe | bPortOe, 18'h00000, "floating after reset");
      scenTransparent();
      scenHold();
      scenClock();
      scenFloat();
      scenReverse();
      scenTestMode();
      scenUpper();
      report_and_stop();
   end

   initial begin
      #(25 * 2000);
      errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
